// *** rtl/ipm_defs.svh ***
// Offsets, field positions, reset values and vector numbers of the pending/mask block.
// Assumes byte addresses on an 8-bit register port with 32-bit data.
`ifndef IPM_DEFS_SVH
`define IPM_DEFS_SVH

`define IPM_OFS_PEND_HIGH 8'h00
`define IPM_OFS_PEND_LOW 8'h04
`define IPM_OFS_MASK_HIGH 8'h08
`define IPM_OFS_MASK_LOW 8'h0C
`define IPM_OFS_EVT_STATUS 8'h1C
`define IPM_OFS_EVT_MASK 8'h20

`define IPM_NUM_SRC 64
`define IPM_SRC_FIRST 1
`define IPM_WORD_W 32
`define IPM_GLOBAL_MASK_BIT 0
`define IPM_PEND_RESET 64'h0000_0000_0000_0000
`define IPM_MASK_RESET 64'hFFFF_FFFF_FFFF_FFFF
`define IPM_WORD_ZERO 32'h0000_0000
`define IPM_HIGH_MSB 63
`define IPM_HIGH_LSB 32
`define IPM_LOW_MSB 31
`define IPM_LOW_LSB 0
`define IPM_VEC_NONE 8'h00

`define IPM_SPURIOUS_VEC 8'h18
`define IPM_VEC_BASE 8'h40
`define IPM_LEVEL_NONE 3'h0

`define IPM_EVT_W 4
`define IPM_EVT_GLOBAL_MASK_TRIGGER 0
`define IPM_EVT_RO_WRITE 1
`define IPM_EVT_SPURIOUS 2
`define IPM_EVT_NEW_REQ 3
`define IPM_EVT_STATUS_RESET 4'h0
`define IPM_EVT_MASK_RESET 4'hF

`endif

// *** rtl/ipm_pkg.sv ***
// Types of the pending/mask block: bus request, acknowledge request, level map, state.
// Assumes ipm_defs.svh is on the include path.
`include "ipm_defs.svh"

package ipm_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } ipm_bus_req_type;

    typedef struct packed {
        logic valid;
        logic [2:0] level;
    } ipm_ack_req_type;

    typedef logic [`IPM_NUM_SRC-1:0][2:0] ipm_level_map_type;

    typedef struct packed {
        logic [`IPM_NUM_SRC-1:0] pending;
        logic [`IPM_NUM_SRC-1:0] mask;
        logic [`IPM_NUM_SRC-1:0] eff;
        logic [`IPM_EVT_W-1:0] evt_status;
        logic [`IPM_EVT_W-1:0] evt_mask;
        logic irq;
        logic [31:0] rdata;
        logic ack_valid;
        logic [7:0] ack_vector;
    } ipm_state_type;

endpackage

// *** rtl/ipm_sync.sv ***
// Three-stage input synchroniser for a vector of request pins.
// Assumes asynchronous inputs; output changes only when stages two and three agree.
`timescale 1ns/1ps

module ipm_sync #(
    parameter int WIDTH = 63
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } ipm_sync_state_type;

    ipm_sync_state_type state;
    ipm_sync_state_type next_state;

    always_comb
    begin
        next_state = state;
        next_state.s1 = async_in;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        // Take the new level only where stages two and three agree
        next_state.out = (~(state.s2 ^ state.s3) & state.s3) | ((state.s2 ^ state.s3) & state.out);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign sync_out = state.out;

endmodule

// *** rtl/ipm_regs.sv ***
// Pending and mask maps of one interrupt controller, with register port,
// effective request vector, spurious acknowledge answer and event interrupt.
// Assumes request pins are asynchronous and the level map comes from level control logic.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "ipm_defs.svh"

module ipm_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [`IPM_NUM_SRC-1:`IPM_SRC_FIRST] src_req,
    input wire ipm_pkg::ipm_bus_req_type bus_req,
    output logic [31:0] bus_rdata,
    input wire ipm_pkg::ipm_ack_req_type ack_req,
    input wire ipm_pkg::ipm_level_map_type src_level,
    output logic ack_valid,
    output logic [7:0] ack_vector,
    output logic [`IPM_NUM_SRC-1:0] eff_req,
    output logic evt_irq
);

    logic [`IPM_NUM_SRC-1:`IPM_SRC_FIRST] src_sync;
    ipm_pkg::ipm_state_type state;
    ipm_pkg::ipm_state_type next_state;
    logic [`IPM_EVT_W-1:0] evt_set;
    logic [`IPM_EVT_W-1:0] evt_clr;
    logic [7:0] picked_vec;

    // Request pins cross into the clock domain here
    ipm_sync #(
        .WIDTH(`IPM_NUM_SRC - `IPM_SRC_FIRST)
    ) ipm_sync_i (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(src_req),
        .sync_out(src_sync)
    );

    // Highest numbered active source on the acknowledged level
    function automatic logic [7:0] ipm_pick_vector(
        input logic [`IPM_NUM_SRC-1:0] req,
        input ipm_pkg::ipm_level_map_type lvl,
        input logic [2:0] level
    );
        logic [7:0] vec;
        vec = `IPM_SPURIOUS_VEC;
        for (int i = `IPM_SRC_FIRST; i < `IPM_NUM_SRC; i++)
        begin
            if (req[i] && (lvl[i] == level) && (lvl[i] != `IPM_LEVEL_NONE))
            begin
                vec = `IPM_VEC_BASE + 8'(i);
            end
        end
        return vec;
    endfunction

    always_comb
    begin
        next_state = state;
        evt_set = '0;
        evt_clr = '0;
        picked_vec = ipm_pick_vector(state.eff, src_level, ack_req.level);

        // Pending follows the synchronised lines, mask plays no part
        next_state.pending = {src_sync, 1'b0};

        // Register writes
        if (bus_req.we)
        begin
            case (bus_req.addr)
                `IPM_OFS_PEND_HIGH,
                `IPM_OFS_PEND_LOW:
                begin
                    // Write dropped, only flagged
                    evt_set[`IPM_EVT_RO_WRITE] = 1'b1;
                end
                `IPM_OFS_MASK_HIGH:
                begin
                    next_state.mask[`IPM_HIGH_MSB:`IPM_HIGH_LSB] = bus_req.wdata;
                end
                `IPM_OFS_MASK_LOW:
                begin
                    next_state.mask[`IPM_LOW_MSB:`IPM_LOW_LSB] = bus_req.wdata;
                    if (bus_req.wdata[`IPM_GLOBAL_MASK_BIT])
                    begin
                        // Mask-all forces both words to ones
                        next_state.mask = `IPM_MASK_RESET;
                        evt_set[`IPM_EVT_GLOBAL_MASK_TRIGGER] = 1'b1;
                    end
                end
                `IPM_OFS_EVT_STATUS:
                begin
                    evt_clr = bus_req.wdata[`IPM_EVT_W-1:0];
                end
                `IPM_OFS_EVT_MASK:
                begin
                    next_state.evt_mask = bus_req.wdata[`IPM_EVT_W-1:0];
                end
                default:
                begin
                    evt_clr = '0;
                end
            endcase
        end

        // Effective request follows pending and mask of the same cycle
        next_state.eff = next_state.pending & ~next_state.mask;
        if (|(next_state.eff & ~state.eff))
        begin
            evt_set[`IPM_EVT_NEW_REQ] = 1'b1;
        end

        // Acknowledge answer one cycle after the request
        next_state.ack_valid = ack_req.valid;
        next_state.ack_vector = `IPM_VEC_NONE;
        if (ack_req.valid)
        begin
            next_state.ack_vector = picked_vec;
            if (picked_vec == `IPM_SPURIOUS_VEC)
            begin
                evt_set[`IPM_EVT_SPURIOUS] = 1'b1;
            end
        end

        // Sticky events, set wins over clear
        next_state.evt_status = (state.evt_status & ~evt_clr) | evt_set;
        next_state.irq = |(next_state.evt_status & ~next_state.evt_mask);

        // Read data stands only in the cycle after the strobe
        next_state.rdata = `IPM_WORD_ZERO;
        if (bus_req.re)
        begin
            case (bus_req.addr)
                `IPM_OFS_PEND_HIGH:
                begin
                    next_state.rdata = state.pending[`IPM_HIGH_MSB:`IPM_HIGH_LSB];
                end
                `IPM_OFS_PEND_LOW:
                begin
                    next_state.rdata = {state.pending[`IPM_LOW_MSB:`IPM_SRC_FIRST], 1'b0};
                end
                `IPM_OFS_MASK_HIGH:
                begin
                    next_state.rdata = state.mask[`IPM_HIGH_MSB:`IPM_HIGH_LSB];
                end
                `IPM_OFS_MASK_LOW:
                begin
                    next_state.rdata = state.mask[`IPM_LOW_MSB:`IPM_LOW_LSB];
                end
                `IPM_OFS_EVT_STATUS:
                begin
                    next_state.rdata = {{(`IPM_WORD_W-`IPM_EVT_W){1'b0}}, state.evt_status};
                end
                `IPM_OFS_EVT_MASK:
                begin
                    next_state.rdata = {{(`IPM_WORD_W-`IPM_EVT_W){1'b0}}, state.evt_mask};
                end
                default:
                begin
                    next_state.rdata = `IPM_WORD_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state.pending <= `IPM_PEND_RESET;
            state.mask <= `IPM_MASK_RESET;
            state.eff <= `IPM_PEND_RESET;
            state.evt_status <= `IPM_EVT_STATUS_RESET;
            state.evt_mask <= `IPM_EVT_MASK_RESET;
            state.irq <= 1'b0;
            state.rdata <= `IPM_WORD_ZERO;
            state.ack_valid <= 1'b0;
            state.ack_vector <= `IPM_VEC_NONE;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign bus_rdata = state.rdata;
    assign ack_valid = state.ack_valid;
    assign ack_vector = state.ack_vector;
    assign eff_req = state.eff;
    assign evt_irq = state.irq;

endmodule

// *** tb/ipm_regs_properties.sv ***
// Checker of the pending/mask block ports.
// Assumes ipm_pkg and ipm_defs.svh are compiled first.
`timescale 1ns/1ps
`include "ipm_defs.svh"
module ipm_regs_properties (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [`IPM_NUM_SRC-1:`IPM_SRC_FIRST] src_req,
    input wire ipm_pkg::ipm_bus_req_type bus_req,
    input wire logic [31:0] bus_rdata,
    input wire ipm_pkg::ipm_ack_req_type ack_req,
    input wire ipm_pkg::ipm_level_map_type src_level,
    input wire logic ack_valid,
    input wire logic [7:0] ack_vector,
    input wire logic [`IPM_NUM_SRC-1:0] eff_req,
    input wire logic evt_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_reset_state: assert property (disable iff (1'h0) rst |=> eff_req == 64'h0 && !evt_irq)
        else $error("state not cleared in reset");
    a_low_bit0_zero: assert property (bus_req.re && bus_req.addr == 8'h04 |=> bus_rdata[0] == 1'h0)
        else $error("low pending bit zero read as one");
    a_mask_all_eff: assert property (bus_req.we && bus_req.addr == 8'h0C && bus_req.wdata[0] |=> (eff_req == 64'h0) [*2])
        else $error("request left after mask-all");
    a_ack_pulse: assert property (1'h1 |=> ack_valid == $past(ack_req.valid))
        else $error("acknowledge answer not one cycle later");
    a_spurious_vec: assert property (ack_req.valid && eff_req == 64'h0 |=> ack_vector == 8'h18)
        else $error("spurious vector wrong");
    a_vector_idle: assert property (!ack_req.valid |=> ack_vector == 8'h00)
        else $error("vector shown without acknowledge");
    a_pend_latency: assert property ($rose(eff_req[1]) |-> $past(src_req[1], 5))
        else $error("request without pin");
    a_rdata_idle: assert property (!bus_req.re |=> bus_rdata == 32'h0)
        else $error("read data outside read cycle");
    a_eff_bit0: assert property (eff_req[0] == 1'h0)
        else $error("request bit zero set");
    cover property (ack_req.valid && eff_req != 64'h0);
    cover property (bus_req.we && bus_req.addr == 8'h0C && bus_req.wdata[0]);
    cover property ($rose(evt_irq));
endmodule
bind ipm_regs ipm_regs_properties ipm_regs_properties_i (.core_clk(core_clk), .rst(rst), .src_req(src_req),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .ack_req(ack_req), .src_level(src_level), .ack_valid(ack_valid),
    .ack_vector(ack_vector), .eff_req(eff_req), .evt_irq(evt_irq));

// *** tb/ipm_src_model.sv ***
// Model of the peripheral request sources.
// Assumes the bench picks the active sources; lines move just after an edge.
`timescale 1ns/1ps
module ipm_src_model (
    input wire logic core_clk,
    input wire logic [63:1] want,
    output logic [63:1] src_req
);
    // Level requests held until dropped
    always_ff @(posedge core_clk)
    begin
        src_req <= want;
    end
endmodule

// *** tb/ipm_regs_tb.sv ***
// Bench of the pending/mask block: registers, pins, acknowledge, events.
// Assumes design, source model and checker are compiled first.
`timescale 1ns/1ps
module ipm_regs_tb;
    typedef struct packed {
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [7:0] raddr;
        logic [31:0] exp;
    } ipm_row_type;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic [63:1] pins_want = '0;
    logic [63:1] src_req;
    ipm_pkg::ipm_bus_req_type bus_req = '0;
    ipm_pkg::ipm_ack_req_type ack_req = '0;
    ipm_pkg::ipm_level_map_type src_level = '0;
    logic [31:0] bus_rdata;
    logic ack_valid;
    logic evt_irq;
    logic [7:0] ack_vector;
    logic [63:0] eff_req;
    int num_errors = 0;
    int compares = 0;
    ipm_row_type rows [8] = '{'{8'h3C, 32'h1234_5678, 8'h08, 32'hFFFF_FFFF},
        '{8'h3C, 32'h1234_5678, 8'h0C, 32'hFFFF_FFFF}, '{8'h00, 32'hFFFF_FFFF, 8'h00, 32'h0},
        '{8'h04, 32'hFFFF_FFFF, 8'h04, 32'h0}, '{8'h08, 32'hA5A5_5A5A, 8'h08, 32'hA5A5_5A5A},
        '{8'h0C, 32'h0000_0002, 8'h0C, 32'h0000_0002}, '{8'h0C, 32'h0000_0001, 8'h08, 32'hFFFF_FFFF},
        '{8'h3C, 32'h1234_5678, 8'h3C, 32'h0}};
    ipm_regs ipm_regs_i (.core_clk(core_clk), .rst(rst), .src_req(src_req), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .ack_req(ack_req), .src_level(src_level), .ack_valid(ack_valid),
        .ack_vector(ack_vector), .eff_req(eff_req), .evt_irq(evt_irq));
    ipm_src_model ipm_src_model_i (.core_clk(core_clk), .want(pins_want), .src_req(src_req));
    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        compares++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{a, d, 1'h1, 1'h0};
        @(posedge core_clk);
        bus_req.we <= 1'h0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk);
        bus_req <= '{a, 32'h0, 1'h0, 1'h1};
        @(posedge core_clk);
        bus_req.re <= 1'h0;
        #1;
        chk("bus_rdata", {32'h0, bus_rdata}, {32'h0, e});
    endtask
    task automatic ack(input logic [2:0] l, input logic [7:0] e);
        @(posedge core_clk);
        ack_req <= '{1'h1, l};
        @(posedge core_clk);
        ack_req.valid <= 1'h0;
        #1;
        chk("ack_valid", {63'h0, ack_valid}, 64'h1);
        chk("ack_vector", {56'h0, ack_vector}, {56'h0, e});
    endtask
    task automatic print_verdict();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        #200000;
        num_errors++;
        print_verdict();
    end
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst <= 1'h0;
        foreach (rows[i])
        begin
            wr(rows[i].waddr, rows[i].wdata);
            rd(rows[i].raddr, rows[i].exp);
        end
        wr(8'h08, 32'h0);
        wr(8'h0C, 32'h0);
        @(posedge core_clk);
        pins_want <= 63'h0000_0080_0000_0001;
        src_level[40] <= 3'h3;
        repeat (10) @(posedge core_clk);
        rd(8'h04, 32'h0000_0002);
        rd(8'h00, 32'h0000_0100);
        chk("eff_req", eff_req, 64'h0000_0100_0000_0002);
        ack(3'h3, 8'h68);
        wr(8'h04, 32'hFFFF_FFFF);
        rd(8'h0C, 32'h0);
        chk("eff_req", eff_req, 64'h0000_0100_0000_0002);
        wr(8'h0C, 32'h0000_0002);
        rd(8'h04, 32'h0000_0002);
        chk("eff_req", eff_req, 64'h0000_0100_0000_0000);
        @(posedge core_clk);
        pins_want <= '0;
        repeat (10) @(posedge core_clk);
        rd(8'h00, 32'h0);
        ack(3'h3, 8'h18);
        chk("evt_irq", {63'h0, evt_irq}, 64'h0);
        wr(8'h20, 32'h0);
        chk("evt_irq", {63'h0, evt_irq}, 64'h1);
        rd(8'h20, 32'h0);
        rd(8'h1C, 32'h0000_000F);
        wr(8'h1C, 32'h0000_000F);
        chk("evt_irq", {63'h0, evt_irq}, 64'h0);
        rd(8'h1C, 32'h0);
        // Mid-run reset with a live pin and a stored mask word
        @(posedge core_clk);
        pins_want <= 63'h0000_0000_0000_0001;
        wr(8'h08, 32'h1234_5678);
        repeat (6) @(posedge core_clk);
        rd(8'h04, 32'h0000_0002);
        @(posedge core_clk);
        rst <= 1'h1;
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        #1;
        chk("eff_req", eff_req, 64'h0);
        chk("evt_irq", {63'h0, evt_irq}, 64'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'hFFFF_FFFF);
        rd(8'h0C, 32'hFFFF_FFFF);
        print_verdict();
    end
endmodule
